//--- design/pet_trace_buffer.sv
`timescale 1ns/10ps
module pet_trace_buffer
    import pet_pkg::*;
#(
    parameter int DEPTH = 4096,
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [PET_ITEM_W-1:0] wr_data,
    input wire logic rd_en,
    output logic [PET_ITEM_W-1:0] rd_data,
    output logic [AW:0] count,
    output logic full
);
    logic [PET_ITEM_W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic do_wr;
    logic do_rd;

    assign full = (count == (AW+1)'(DEPTH));
    assign do_wr = wr_en && !full;
    // reading an empty buffer is a software error; the last item simply stays
    assign do_rd = rd_en && (count != '0);

    // no reset on the array so it maps onto block or distributed ram
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            count <= '0;
            rd_data <= '0;
        end else if (clear) begin
            wp_r <= '0;
            rp_r <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= AW'(wp_r + 1'b1);
            end
            if (do_rd) begin
                rp_r <= AW'(rp_r + 1'b1);
                rd_data <= mem[rp_r];
            end
            count <= (AW+1)'(count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
        end
    end

endmodule : pet_trace_buffer

//--- design/pet_unit.sv
`timescale 1ns/10ps
// Behaviour
// - buffer size parameter, 8KB to 128KB
// - external trace: 8KB or 32B-256B buffer
// - size zero removes program trace
// - complete level: 144-bit entry per instruction
// - complete level off for external/64-bit
// - flow level: branch outcomes, indirect PCs
// - optional PC for returns or taken branches
// - optionally record loaded data
// - dynamic branch slot: data before PC
// - static branch slot: flow before data
// - flow levels: events recorded, each preceded by PC
// - xori to r0 is software event
// - cycle level adds inter-instruction cycle count
// - event level: events, cycle events, optional PC
// - event level: optional call/return PCs
// - start: command, tracepoint, cross trigger
// - stop: full, command, cross trigger
// - cycle limits 32768/8192; overflow flag
// - optional halt on full or overflow
// - control 0x61, command 0x62, write only
// - status read by 0x63, read only
// - data read by 0x66, oldest item
// - level codes 00/01/10/11
// - started/overflow flag set and clear
// - each data read advances to next
//
module pet_unit
    import pet_pkg::*;
#(
    parameter int TRACE_SIZE = 8192,
    parameter bit EXTERNAL_TRACE = 1'b0,
    parameter bit DATA_64 = 1'b0
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] DBG_CMD,
    input wire logic DBG_CMD_VALID,
    input wire logic [PET_CTRL_W-1:0] DBG_WDATA,
    output logic [PET_ITEM_W-1:0] DBG_RDATA,
    output logic DBG_RVALID,
    input wire pet_retire_t RETIRE,
    input wire logic [PET_TP_W-1:0] BKPT_HIT,
    input wire pet_xtrig_t XTRIG,
    input wire logic TRACE_READY,
    output pet_item_out_t TRACE_OUT,
    output logic CORE_STALL,
    output logic CORE_HALT
);
    // byte size sets the item depth: 8KB holds 512 complete entries
    localparam bit HAS_TRACE = (TRACE_SIZE > 0);
    localparam int DEPTH_RAW = TRACE_SIZE / PET_BYTES_PER_ITEM;
    localparam int DEPTH = (DEPTH_RAW < 2) ? 2 : DEPTH_RAW;
    localparam int AW = $clog2(DEPTH);
    localparam bit COMPLETE_OK = !EXTERNAL_TRACE && !DATA_64;

    typedef enum logic {PET_IDLE, PET_RUN} pet_state_t;

    function automatic logic [PET_ITEM_W-1:0] mk_item(input logic [1:0] tag,
                                                     input logic [15:0] payload);
        mk_item = {tag, payload};
    endfunction : mk_item

    ////////////////////////////////////////////////////////////////////////////////
    // debug register decode
    logic [PET_CTRL_W-1:0] ctrl_r;
    pet_state_t state_r;
    logic ovf_r;
    logic [15:0] sampled_r;
    logic wr_ctrl;
    logic wr_cmd;
    logic rd_stat;
    logic rd_item;
    logic cmd_clear;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_sample;
    logic [1:0] lvl;
    logic compl_mode;
    logic tracing;

    assign wr_ctrl = DBG_CMD_VALID && (DBG_CMD == PET_CMD_CTRL);
    assign wr_cmd = DBG_CMD_VALID && (DBG_CMD == PET_CMD_CMD);
    assign rd_stat = DBG_CMD_VALID && (DBG_CMD == PET_CMD_STATUS);
    assign rd_item = DBG_CMD_VALID && (DBG_CMD == PET_CMD_DATA) && !EXTERNAL_TRACE;
    assign cmd_clear = wr_cmd && DBG_WDATA[PET_C_CLEAR];
    assign cmd_start = wr_cmd && DBG_WDATA[PET_C_START];
    assign cmd_stop = wr_cmd && DBG_WDATA[PET_C_STOP];
    assign cmd_sample = wr_cmd && DBG_WDATA[PET_C_SAMPLE];
    assign lvl = ctrl_r[PET_LVL_LSB +: 2];
    assign compl_mode = COMPLETE_OK && (lvl == PET_LVL_COMPLETE);
    assign tracing = (state_r == PET_RUN);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r <= PET_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= DBG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffer instance; absent when size is zero
    logic buf_wr;
    logic buf_rd;
    logic buf_full;
    logic [AW:0] buf_count;
    logic [PET_ITEM_W-1:0] buf_rdata;
    logic [PET_ITEM_W-1:0] pend_r [PET_STAGE_N];
    logic [3:0] pend_n_r;
    logic pop;
    logic out_valid_r;
    logic drain;

    assign pop = (pend_n_r != 4'h0);
    assign buf_wr = pop && HAS_TRACE;
    // in external mode the buffer only smooths bursts toward the debug module
    assign drain = EXTERNAL_TRACE && (buf_count != '0) && (!out_valid_r || TRACE_READY);
    assign buf_rd = EXTERNAL_TRACE ? drain : rd_item;

    generate
        if (HAS_TRACE) begin : g_buf
            pet_trace_buffer #(
                .DEPTH(DEPTH),
                .AW(AW)
            ) u_buf (
                .clk(SYS_CLK),
                .rst_n(RESET_N),
                .clear(cmd_clear),
                .wr_en(buf_wr),
                .wr_data(pend_r[0]),
                .rd_en(buf_rd),
                .rd_data(buf_rdata),
                .count(buf_count),
                .full(buf_full)
            );
        end else begin : g_nobuf
            assign buf_rdata = '0;
            assign buf_count = '0;
            assign buf_full = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // start / stop
    logic start_any;
    logic stop_any;

    assign start_any = HAS_TRACE && (cmd_start || |(BKPT_HIT & ctrl_r[PET_TP_LSB +: PET_TP_W])
                       || XTRIG.start);
    assign stop_any = cmd_stop || XTRIG.stop || buf_full;

    // a stop in the same cycle as a start wins, so a full buffer never restarts
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= PET_IDLE;
        end else if (cmd_clear) begin
            state_r <= PET_IDLE;
        end else begin
            case (state_r)
                PET_IDLE: begin
                    if (start_any && !stop_any) begin
                        state_r <= PET_RUN;
                    end
                end
                PET_RUN: begin
                    if (stop_any) begin
                        state_r <= PET_IDLE;
                    end
                end
                default: begin
                    state_r <= PET_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cycle counter
    logic [15:0] cyc_r;
    logic [15:0] cyc_lim;
    logic cyc_emit;
    logic ovf_evt;

    assign cyc_lim = compl_mode ? 16'(PET_CYC_LIM_COMPLETE - 1) : 16'(PET_CYC_LIM_FLOW - 1);
    assign ovf_evt = tracing && !cyc_emit && (cyc_r == cyc_lim) && !ovf_r
                     && (compl_mode || lvl == PET_LVL_FLOWCYC);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cyc_r <= '0;
        end else if (!tracing || cyc_emit || cmd_clear) begin
            cyc_r <= '0;
        end else if (cyc_r != cyc_lim) begin
            cyc_r <= 16'(cyc_r + 16'h0001); // saturates at the limit
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // item compression
    logic [PET_ITEM_W-1:0] stg [PET_STAGE_N];
    int n;
    logic [PET_ENTRY_W-1:0] entry;
    logic [11:0] flow_r;
    logic [11:0] flow_nxt;
    logic [3:0] fcnt_r;
    logic [3:0] fcnt_nxt;
    logic has_evt;
    logic [PET_ITEM_W-1:0] evt_item;
    logic data_rec;
    logic pc_rec;
    logic flush;
    logic [31:0] pc_val;

    always_comb begin
        n = 0;
        for (int i = 0; i < PET_STAGE_N; i++) begin
            stg[i] = '0;
        end
        flow_nxt = flow_r;
        fcnt_nxt = fcnt_r;
        cyc_emit = 1'b0;
        entry = '0;
        data_rec = 1'b0;
        pc_rec = 1'b0;
        flush = 1'b0;
        has_evt = 1'b1;
        pc_val = RETIRE.valid ? RETIRE.target : RETIRE.pc;
        if (RETIRE.valid && RETIRE.exc) begin
            evt_item = mk_item(PET_TAG_EVENT, {PET_EVT_EXC, 8'h00, RETIRE.exc_kind});
        end else if (RETIRE.valid && RETIRE.irq) begin
            evt_item = mk_item(PET_TAG_EVENT, {PET_EVT_IRQ, 13'h0000});
        end else if (RETIRE.valid && RETIRE.brk) begin
            evt_item = mk_item(PET_TAG_EVENT, {PET_EVT_BRK, 13'h0000});
        end else if (XTRIG.evt != 4'h0) begin
            evt_item = mk_item(PET_TAG_EVENT, {PET_EVT_XTRIG, 9'h000, XTRIG.evt});
        end else if (RETIRE.valid && RETIRE.xori_r0) begin
            evt_item = mk_item(PET_TAG_EVENT, {PET_EVT_SW, RETIRE.imm[12:0]});
        end else begin
            evt_item = '0;
            has_evt = 1'b0;
        end
        if (tracing && compl_mode) begin
            if (RETIRE.valid) begin
                entry = {cyc_r[14:0], RETIRE.msr, RETIRE.rd_addr, RETIRE.rd_wr,
                         RETIRE.exc_kind, RETIRE.exc, RETIRE.ld_valid, RETIRE.st_valid,
                         RETIRE.byte_en, RETIRE.st_valid ? RETIRE.st_data : RETIRE.rd_data,
                         RETIRE.pc, RETIRE.instr};
                for (int i = 0; i < PET_ENTRY_ITEMS; i++) begin
                    stg[i] = entry[PET_ENTRY_W-1-PET_ITEM_W*i -: PET_ITEM_W];
                end
                n = PET_ENTRY_ITEMS;
                cyc_emit = 1'b1;
            end
        end else if (tracing && lvl != PET_LVL_EVENT) begin
            data_rec = RETIRE.valid && RETIRE.ld_valid && ctrl_r[PET_SAVE_LD];
            pc_rec = has_evt || (RETIRE.valid && RETIRE.branch && RETIRE.taken
                     && (RETIRE.dynamic || ctrl_r[PET_SAVE_PC]
                     || (RETIRE.is_return && ctrl_r[PET_SAVE_RET])));
            if (has_evt) begin
                pc_val = RETIRE.pc;
            end
            if (RETIRE.valid && RETIRE.branch) begin
                flow_nxt[fcnt_r] = RETIRE.taken;
                fcnt_nxt = 4'(fcnt_r + 4'h1);
            end
            flush = (fcnt_nxt != 4'h0)
                    && (fcnt_nxt == 4'(PET_FLOW_BITS) || data_rec || pc_rec);
            if (lvl == PET_LVL_FLOWCYC && (flush || data_rec || pc_rec)) begin
                stg[n] = mk_item(PET_TAG_EVENT, {PET_EVT_CYC, cyc_r[12:0]});
                n = n + 1;
                cyc_emit = 1'b1;
            end
            if (flush) begin
                stg[n] = mk_item(PET_TAG_FLOW, {fcnt_nxt, flow_nxt});
                n = n + 1;
                flow_nxt = '0;
                fcnt_nxt = 4'h0;
            end
            if (data_rec) begin
                stg[n] = mk_item(PET_TAG_DATA, RETIRE.ld_data[31:16]);
                stg[n+1] = mk_item(PET_TAG_DATA, RETIRE.ld_data[15:0]);
                n = n + 2;
            end
            if (pc_rec) begin
                stg[n] = mk_item(PET_TAG_ADDR, pc_val[31:16]);
                stg[n+1] = mk_item(PET_TAG_ADDR, pc_val[15:0]);
                n = n + 2;
            end
            if (has_evt) begin
                stg[n] = evt_item;
                n = n + 1;
            end
        end else if (tracing) begin
            pc_rec = (has_evt && ctrl_r[PET_SAVE_PC]) || (RETIRE.valid
                     && ((RETIRE.is_call && ctrl_r[PET_SAVE_PC])
                     || (RETIRE.is_return && ctrl_r[PET_SAVE_RET])));
            if (has_evt) begin
                pc_val = RETIRE.pc;
            end
            if (has_evt || cyc_r == cyc_lim) begin
                stg[n] = mk_item(PET_TAG_EVENT, {PET_EVT_CYC, cyc_r[12:0]});
                n = n + 1;
                cyc_emit = 1'b1;
            end
            if (pc_rec) begin
                stg[n] = mk_item(PET_TAG_ADDR, pc_val[31:16]);
                stg[n+1] = mk_item(PET_TAG_ADDR, pc_val[15:0]);
                n = n + 2;
            end
            if (has_evt) begin
                stg[n] = evt_item;
                n = n + 1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flow_r <= '0;
            fcnt_r <= 4'h0;
        end else if (cmd_clear || !tracing) begin
            flow_r <= '0;
            fcnt_r <= 4'h0;
        end else begin
            flow_r <= flow_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pending item queue, one item to the buffer per cycle
    logic [PET_ITEM_W-1:0] pend_nxt [PET_STAGE_N];
    logic [3:0] pend_n_nxt;
    int base;

    always_comb begin
        base = int'(pend_n_r);
        for (int i = 0; i < PET_STAGE_N; i++) begin
            pend_nxt[i] = pend_r[i];
        end
        if (pop) begin
            for (int i = 0; i < PET_STAGE_N - 1; i++) begin
                pend_nxt[i] = pend_r[i+1];
            end
            pend_nxt[PET_STAGE_N-1] = '0;
            base = base - 1;
        end
        for (int i = 0; i < PET_STAGE_N; i++) begin
            if (i < n && base + i < PET_STAGE_N) begin
                pend_nxt[base+i] = stg[i];
            end
        end
        pend_n_nxt = (base + n > PET_STAGE_N) ? 4'(PET_STAGE_N) : 4'(base + n);
    end

    // stall is registered, so it rises as soon as more than one item waits
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < PET_STAGE_N; i++) begin
                pend_r[i] <= '0;
            end
            pend_n_r <= 4'h0;
            CORE_STALL <= 1'b0;
        end else if (cmd_clear) begin
            pend_n_r <= 4'h0;
            CORE_STALL <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            pend_n_r <= pend_n_nxt;
            CORE_STALL <= (pend_n_nxt > 4'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status, halt and read answers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ovf_r <= 1'b0;
        end else if (ovf_evt) begin
            ovf_r <= 1'b1; // set wins over a clear in the same cycle
        end else if (cmd_clear) begin
            ovf_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sampled_r <= PET_COUNT_RST;
        end else if (cmd_clear) begin
            sampled_r <= PET_COUNT_RST;
        end else if (cmd_sample) begin
            sampled_r <= (buf_count > (AW+1)'(PET_COUNT_MAX)) ? PET_COUNT_MAX
                         : 16'(buf_count);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CORE_HALT <= 1'b0;
        end else if (ctrl_r[PET_FULL_HALT] && ((tracing && buf_full) || ovf_evt)) begin
            CORE_HALT <= 1'b1;
        end else if (cmd_start || cmd_clear) begin
            CORE_HALT <= 1'b0;
        end
    end

    logic rd_stat_q;
    logic rd_item_q;

    // both reads answer two edges after the command, matching the buffer latency
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_stat_q <= 1'b0;
            rd_item_q <= 1'b0;
            DBG_RVALID <= 1'b0;
            DBG_RDATA <= '0;
        end else begin
            rd_stat_q <= rd_stat;
            rd_item_q <= rd_item;
            DBG_RVALID <= rd_stat_q || rd_item_q;
            if (rd_stat_q) begin
                DBG_RDATA <= {tracing, ovf_r, sampled_r};
            end else if (rd_item_q) begin
                DBG_RDATA <= buf_rdata;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_valid_r <= 1'b0;
        end else if (drain) begin
            out_valid_r <= 1'b1;
        end else if (TRACE_READY) begin
            out_valid_r <= 1'b0;
        end
    end

    assign TRACE_OUT.valid = out_valid_r;
    assign TRACE_OUT.item = buf_rdata;

endmodule : pet_unit

//--- include/pet_pkg.sv
package pet_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // debug command codes and the matching access select values
    localparam logic [7:0] PET_CMD_CTRL = 8'h61;
    localparam logic [7:0] PET_CMD_CMD = 8'h62;
    localparam logic [7:0] PET_CMD_STATUS = 8'h63;
    localparam logic [7:0] PET_CMD_DATA = 8'h66;
    localparam logic [19:0] PET_SEL_CTRL = 20'h4_C215;
    localparam logic [19:0] PET_SEL_CMD = 20'h4_C403;
    localparam logic [19:0] PET_SEL_STATUS = 20'h4_C611;
    localparam logic [19:0] PET_SEL_DATA = 20'h4_CC11;

    ////////////////////////////////////////////////////////////////////////////////
    // register widths, fields and reset values
    localparam int PET_CTRL_W = 22;
    localparam int PET_CMDR_W = 4;
    localparam int PET_STAT_W = 18;
    localparam int PET_ITEM_W = 18;
    localparam int PET_TP_LSB = 6;
    localparam int PET_TP_W = 16;
    localparam int PET_LVL_LSB = 4;
    localparam int PET_FULL_HALT = 3;
    localparam int PET_SAVE_PC = 2;
    localparam int PET_SAVE_LD = 1;
    localparam int PET_SAVE_RET = 0;
    localparam int PET_C_CLEAR = 3;
    localparam int PET_C_START = 2;
    localparam int PET_C_STOP = 1;
    localparam int PET_C_SAMPLE = 0;
    localparam int PET_S_STARTED = 17;
    localparam int PET_S_OVF = 16;
    localparam logic [PET_CTRL_W-1:0] PET_CTRL_RST = 22'h00_0000;
    localparam logic [15:0] PET_COUNT_RST = 16'h0000;
    localparam logic [15:0] PET_COUNT_MAX = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////////////
    // compression levels, item tags and event classes
    localparam logic [1:0] PET_LVL_COMPLETE = 2'h0;
    localparam logic [1:0] PET_LVL_FLOW = 2'h1;
    localparam logic [1:0] PET_LVL_EVENT = 2'h2;
    localparam logic [1:0] PET_LVL_FLOWCYC = 2'h3;
    localparam logic [1:0] PET_TAG_FLOW = 2'h0;
    localparam logic [1:0] PET_TAG_ADDR = 2'h1;
    localparam logic [1:0] PET_TAG_DATA = 2'h2;
    localparam logic [1:0] PET_TAG_EVENT = 2'h3;
    localparam logic [2:0] PET_EVT_EXC = 3'h0;
    localparam logic [2:0] PET_EVT_IRQ = 3'h1;
    localparam logic [2:0] PET_EVT_BRK = 3'h2;
    localparam logic [2:0] PET_EVT_XTRIG = 3'h3;
    localparam logic [2:0] PET_EVT_SW = 3'h4;
    localparam logic [2:0] PET_EVT_CYC = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // sizes and timing counts
    localparam int PET_CYC_LIM_COMPLETE = 32768;
    localparam int PET_CYC_LIM_FLOW = 8192;
    localparam int PET_ENTRY_W = 144;
    localparam int PET_ENTRY_ITEMS = 8;
    localparam int PET_STAGE_N = 8;
    localparam int PET_FLOW_BITS = 12;
    localparam int PET_BYTES_PER_ITEM = 2;

    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        logic [31:0] target;
        logic [31:0] instr;
        logic branch;
        logic taken;
        logic dynamic;
        logic is_return;
        logic is_call;
        logic ld_valid;
        logic [31:0] ld_data;
        logic st_valid;
        logic [3:0] byte_en;
        logic [31:0] st_data;
        logic rd_wr;
        logic [4:0] rd_addr;
        logic [31:0] rd_data;
        logic [14:0] msr;
        logic exc;
        logic [4:0] exc_kind;
        logic irq;
        logic brk;
        logic xori_r0;
        logic [15:0] imm;
    } pet_retire_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic [3:0] evt;
    } pet_xtrig_t;

    typedef struct packed {
        logic valid;
        logic [PET_ITEM_W-1:0] item;
    } pet_item_out_t;

endpackage : pet_pkg

//--- tb/pet_dbg_model.sv
`timescale 1ns/10ps
module pet_dbg_model
    import pet_pkg::*;
(
    input wire logic SYS_CLK,
    output logic [7:0] DBG_CMD,
    output logic DBG_CMD_VALID,
    output logic [PET_CTRL_W-1:0] DBG_WDATA,
    input wire logic [PET_ITEM_W-1:0] DBG_RDATA,
    input wire logic DBG_RVALID
);
    initial begin
        DBG_CMD = 8'h00;
        DBG_CMD_VALID = 1'b0;
        DBG_WDATA = 22'h00_0000;
    end
    task automatic wr(input logic [7:0] c, input logic [PET_CTRL_W-1:0] d);
        @(negedge SYS_CLK);
        DBG_CMD = c;
        DBG_WDATA = d;
        DBG_CMD_VALID = 1'b1;
        @(negedge SYS_CLK);
        DBG_CMD_VALID = 1'b0;
        // released data is inverted, not held
        DBG_WDATA = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [PET_ITEM_W-1:0] q, output bit ok);
        int n;
        wr(c, 22'h00_0000);
        n = 0;
        while (DBG_RVALID !== 1'b1 && n < 4) begin
            @(negedge SYS_CLK);
            n++;
        end
        q = DBG_RDATA;
        ok = DBG_RVALID === 1'b1;
    endtask : rd
endmodule : pet_dbg_model

//--- tb/pet_monitor.sv
`timescale 1ns/10ps
module pet_monitor
    import pet_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] DBG_CMD,
    input wire logic DBG_CMD_VALID,
    input wire logic [PET_CTRL_W-1:0] DBG_WDATA,
    input wire logic [PET_ITEM_W-1:0] DBG_RDATA,
    input wire logic DBG_RVALID,
    input wire pet_item_out_t TRACE_OUT,
    input wire logic CORE_HALT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    wire rd_st = DBG_CMD_VALID && DBG_CMD == PET_CMD_STATUS;
    wire rd_it = DBG_CMD_VALID && DBG_CMD == PET_CMD_DATA;
    wire rd_any = rd_st || rd_it;
    wire wr_any = DBG_CMD_VALID && (DBG_CMD == PET_CMD_CTRL || DBG_CMD == PET_CMD_CMD);
    wire go = DBG_CMD_VALID && DBG_CMD == PET_CMD_CMD && (DBG_WDATA[2] || DBG_WDATA[3]);
    logic halt_en_r;
    // halt may only come from a full-halt setting already written
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N)
            halt_en_r <= 1'b0;
        else if (DBG_CMD_VALID && DBG_CMD == PET_CMD_CTRL)
            halt_en_r <= DBG_WDATA[PET_FULL_HALT];
    end
    ////////////////////////////////////////////////////////////
    status_answer_a: assert property (rd_st |-> ##2 DBG_RVALID)
        else $error("status read not answered");
    item_answer_a: assert property (rd_it |-> ##2 DBG_RVALID)
        else $error("item read not answered");
    write_silent_a: assert property (wr_any |-> ##2 !DBG_RVALID)
        else $error("write answered");
    answer_cause_a: assert property (DBG_RVALID |-> $past(rd_any, 2))
        else $error("answer without read");
    rdata_hold_a: assert property (!DBG_RVALID |-> $stable(DBG_RDATA))
        else $error("read data moved");
    halt_gate_a: assert property ($rose(CORE_HALT) |-> halt_en_r)
        else $error("halt without full halt");
    halt_hold_a: assert property (CORE_HALT && !go |=> CORE_HALT)
        else $error("halt dropped");
    ext_idle_a: assert property (!TRACE_OUT.valid)
        else $error("external output active");
endmodule : pet_monitor

//--- tb/tb_pet_unit.sv
`timescale 1ns/10ps
module tb_pet_unit
    import pet_pkg::*;
;
    logic sys_clk, reset_n, dbg_cmd_valid, dbg_rvalid, core_halt;
    logic [7:0] dbg_cmd;
    logic [PET_CTRL_W-1:0] dbg_wdata;
    logic [PET_ITEM_W-1:0] dbg_rdata, q;
    logic [PET_TP_W-1:0] bkpt_hit;
    pet_retire_t retire;
    pet_xtrig_t xtrig;
    pet_item_out_t trace_out;
    int errors, checks_done, cycles;
    bit ok;
    pet_unit #(.TRACE_SIZE(8192)) i_pet_unit (.SYS_CLK(sys_clk), .RESET_N(reset_n),
        .DBG_CMD(dbg_cmd), .DBG_CMD_VALID(dbg_cmd_valid), .DBG_WDATA(dbg_wdata),
        .DBG_RDATA(dbg_rdata), .DBG_RVALID(dbg_rvalid), .RETIRE(retire), .BKPT_HIT(bkpt_hit),
        .XTRIG(xtrig), .TRACE_READY(1'b0), .TRACE_OUT(trace_out), .CORE_STALL(),
        .CORE_HALT(core_halt));
    pet_dbg_model i_pet_dbg_model (.SYS_CLK(sys_clk), .DBG_CMD(dbg_cmd),
        .DBG_CMD_VALID(dbg_cmd_valid), .DBG_WDATA(dbg_wdata), .DBG_RDATA(dbg_rdata),
        .DBG_RVALID(dbg_rvalid));
    task automatic end_of_test;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [PET_ITEM_W-1:0] g, input logic [PET_ITEM_W-1:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, input logic [PET_ITEM_W-1:0] e);
        i_pet_dbg_model.rd(c, q, ok);
        chk(ok ? q : ~e, e);
    endtask : rdc
    task automatic wc(input logic [3:0] c);
        i_pet_dbg_model.wr(PET_CMD_CMD, {18'h0_0000, c});
    endtask : wc
    task automatic ret(input logic [15:0] im);
        @(negedge sys_clk);
        retire.valid = 1'b1;
        retire.xori_r0 = 1'b1;
        retire.imm = im;
        @(negedge sys_clk);
        retire = '0;
    endtask : ret
    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test;
        end
    end
    initial begin
        retire = '0;
        bkpt_hit = 16'h0000;
        xtrig = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        rdc(PET_CMD_STATUS, 18'h0_0000);
        wc(4'h4);
        rdc(PET_CMD_STATUS, 18'h2_0000);
        wc(4'h2);
        rdc(PET_CMD_STATUS, 18'h0_0000);
        @(negedge sys_clk) xtrig.start = 1'b1;
        @(negedge sys_clk) xtrig.start = 1'b0;
        rdc(PET_CMD_STATUS, 18'h2_0000);
        @(negedge sys_clk) xtrig.stop = 1'b1;
        @(negedge sys_clk) xtrig.stop = 1'b0;
        rdc(PET_CMD_STATUS, 18'h0_0000);
        i_pet_dbg_model.wr(PET_CMD_CTRL, 22'h00_0040);
        @(negedge sys_clk) bkpt_hit = 16'h0001;
        @(negedge sys_clk) bkpt_hit = 16'h0000;
        rdc(PET_CMD_STATUS, 18'h2_0000);
        wc(4'h8);
        rdc(PET_CMD_STATUS, 18'h0_0000);
        i_pet_dbg_model.wr(PET_CMD_CTRL, 22'h00_0020);
        wc(4'h4);
        ret(16'h0123);
        ret(16'h1ABC);
        wc(4'h2);
        wc(4'h1);
        rdc(PET_CMD_STATUS, 18'h0_0004);
        rdc(PET_CMD_DATA, 18'h3_A001);
        rdc(PET_CMD_DATA, 18'h3_8123);
        rdc(PET_CMD_DATA, 18'h3_A001);
        rdc(PET_CMD_DATA, 18'h3_9ABC);
        wc(4'h8);
        i_pet_dbg_model.wr(PET_CMD_CTRL, 22'h00_0038);
        wc(4'h4);
        ret(16'h0000);
        // idle gap runs past the cycle limit
        repeat (8300) @(negedge sys_clk);
        chk({17'h0_0000, core_halt}, 18'h0_0001);
        i_pet_dbg_model.rd(PET_CMD_STATUS, q, ok);
        chk({16'h0000, ok, q[PET_S_OVF]}, 18'h0_0003);
        wc(4'h8);
        chk({17'h0_0000, core_halt}, 18'h0_0000);
        i_pet_dbg_model.rd(PET_CMD_STATUS, q, ok);
        chk({16'h0000, ok, q[PET_S_OVF]}, 18'h0_0002);
        end_of_test;
    end
endmodule : tb_pet_unit
bind pet_unit pet_monitor i_pet_monitor (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .DBG_CMD(DBG_CMD), .DBG_CMD_VALID(DBG_CMD_VALID), .DBG_WDATA(DBG_WDATA),
    .DBG_RDATA(DBG_RDATA), .DBG_RVALID(DBG_RVALID), .TRACE_OUT(TRACE_OUT),
    .CORE_HALT(CORE_HALT));
